// file: hdl/lcir_top.sv
// Purpose: input routing front end and mixing cell of a logic cell
// Assumes: every source input is asynchronous to pclk
// Notes:   apb slave, zero wait states, 16-bit registers in low lanes
//
// Operation
// RQ1 - gate invert bit flips that gate output
// RQ2 - selector one picks pin a, clocks, timers
// RQ3 - selector two picks pin b and peripherals
// RQ4 - selector three picks pin c and peripherals
// RQ5 - selector four picks pin d and peripherals
// RQ6 - selector fields packed in four-bit slots
// RQ7 - true enable feeds source uninverted
// RQ8 - negated enable feeds source inverted
// RQ9 - low enable word holds gates one, two
// RQ10 - both enables clear means no contribution
// RQ11 - high enable word holds gates three, four
// RQ12 - mode selects one of eight cell functions
// RQ13 - disabled cell drives zero output
// RQ14 - gate ORs its enabled terms
// RQ15 - unimplemented selector codes route zero
//
// The APB register port was chosen for this implementation.
`default_nettype none
module lcir_top
  import lcir_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cell_input_pin_a,
  input  wire logic        cell_input_pin_b,
  input  wire logic        cell_input_pin_c,
  input  wire logic        cell_input_pin_d,
  input  wire logic        peripheral_bus_clock,
  input  wire logic        secondary_oscillator,
  input  wire logic        low_power_rc_clock,
  input  wire logic        reference_clock_out,
  input  wire logic        timer_two_match,
  input  wire logic        timer_three_match,
  input  wire logic        logic_cell_one,
  input  wire logic        comparator_one,
  input  wire logic        comparator_two,
  input  wire logic        comparator_three,
  input  wire logic        serial_two_transmit,
  input  wire logic        serial_two_receive,
  input  wire logic        adc_done,
  input  wire logic        dma_zero_irq,
  input  wire logic        dma_one_irq,
  input  wire logic        compare_output_one,
  input  wire logic        compare_output_two,
  input  wire logic        compare_output_three,
  input  wire logic        spi_two_data_out,
  input  wire logic        spi_two_data_in,
  output logic      [3:0]  gate_out,
  output logic             cell_out
);

  localparam int NEXT = 24;          // number of outside sources

  // configuration registers
  logic [15:0] ctrl_lo_reg;          // cell_enable and mode
  logic [15:0] ctrl_hi_reg;          // gate invert bits
  logic [15:0] sel_reg;              // four source selectors
  logic [15:0] en_lo_reg;            // gate one/two enables
  logic [15:0] en_hi_reg;            // gate three/four enables
  // synchroniser and routed sources
  logic [NEXT-1:0] ext_meta_reg;     // first stage, read by second only
  logic [NEXT-1:0] ext_sync_reg;     // safe copies
  logic [3:0]  src;                  // selected data sources
  logic [3:0]  gate_raw;             // gate terms before inversion
  logic [31:0] gate_en;              // all four gates' enables
  // cell state
  logic        cell_out_reg;
  logic        cell_next;
  logic        g1_prev_reg;          // gate one last cycle, for edges
  logic        g1_rise;
  lcir_mode_e  mode;
  // bus decode
  logic        setup;
  logic        wr_en;
  logic        hit;
  logic [15:0] rd_word;
  logic        s_pin_a, s_pin_b, s_pin_c, s_pin_d, s_pbclk, s_secondary_oscillator;
  logic        s_low_power_rc_clock, s_reference_clock_out, s_tmr2, s_tmr3, s_cell1, s_cmp1, s_cmp2;
  logic        s_cmp3, s_utx, s_urx, s_adc, s_dma0, s_dma1, s_oc1, s_oc2;
  logic        s_oc3, s_sdo, s_sdi;

  // merge a write into a register, honouring the two low byte lanes
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st,
                                        input logic [15:0] msk);
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r & msk;
  endfunction

  // one gate: OR of enabled true and negated terms
  function automatic logic gate_or(input logic [7:0] en,
                                   input logic [3:0] s);
    logic acc;
    acc = 1'b0;                                   // see RQ10
    for (int k = 0; k < 4; k++) begin
      acc = acc | (en[2*k+1] & s[k]);             // see RQ7
      acc = acc | (en[2*k] & ~s[k]);              // see RQ8
    end
    return acc;                                   // see RQ14
  endfunction

  // decode a byte address to a hit
  function automatic logic is_mapped(input logic [15:0] a);
    return (a == ADDR_CTRL_LO) || (a == ADDR_CTRL_HI) || (a == ADDR_SEL)
        || (a == ADDR_EN_LO) || (a == ADDR_EN_HI);
  endfunction

  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pwrite;        // pready is always high
  assign hit    = is_mapped(paddr);
  assign pready = 1'b1;                           // never stretches access
  assign mode   = lcir_mode_e'(ctrl_lo_reg[2:0]);

  // two-flop synchroniser for every outside source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta_reg <= '0;
      ext_sync_reg <= '0;
    end else begin
      ext_meta_reg <= {cell_input_pin_a, cell_input_pin_b, cell_input_pin_c,
                       cell_input_pin_d, peripheral_bus_clock,
                       secondary_oscillator, low_power_rc_clock,
                       reference_clock_out, timer_two_match,
                       timer_three_match, logic_cell_one, comparator_one,
                       comparator_two, comparator_three, serial_two_transmit,
                       serial_two_receive, adc_done, dma_zero_irq,
                       dma_one_irq, compare_output_one, compare_output_two,
                       compare_output_three, spi_two_data_out,
                       spi_two_data_in};
      ext_sync_reg <= ext_meta_reg;
    end
  end

  assign {s_pin_a, s_pin_b, s_pin_c, s_pin_d, s_pbclk, s_secondary_oscillator, s_low_power_rc_clock,
          s_reference_clock_out, s_tmr2, s_tmr3, s_cell1, s_cmp1, s_cmp2, s_cmp3, s_utx,
          s_urx, s_adc, s_dma0, s_dma1, s_oc1, s_oc2, s_oc3, s_sdo,
          s_sdi} = ext_sync_reg;

  // source selectors; absent codes give zero
  always_comb begin
    case (sel_reg[2:0])                           // see RQ2
      3'h0:    src[0] = s_pin_a;
      3'h1:    src[0] = s_pbclk;
      3'h2:    src[0] = s_secondary_oscillator;
      3'h3:    src[0] = s_low_power_rc_clock;
      3'h4:    src[0] = s_reference_clock_out;
      3'h6:    src[0] = s_tmr2;
      3'h7:    src[0] = s_tmr3;
      default: src[0] = 1'b0;                     // see RQ15
    endcase
    case (sel_reg[6:4])                           // see RQ3
      3'h0:    src[1] = s_pin_b;
      3'h1:    src[1] = s_cell1;
      3'h2:    src[1] = s_cmp1;
      3'h3:    src[1] = s_utx;
      3'h4:    src[1] = s_adc;
      3'h5:    src[1] = s_dma0;
      3'h6:    src[1] = s_oc1;
      default: src[1] = s_oc2;
    endcase
    case (sel_reg[10:8])                          // see RQ4
      3'h0:    src[2] = s_pin_c;
      3'h1:    src[2] = cell_out_reg;             // this cell fed back
      3'h2:    src[2] = s_cmp2;
      3'h3:    src[2] = s_sdo;
      3'h4:    src[2] = s_urx;
      3'h5:    src[2] = s_dma1;
      3'h6:    src[2] = s_oc2;
      default: src[2] = s_oc3;
    endcase
    case (sel_reg[14:12])                         // see RQ5
      3'h0:    src[3] = s_pin_d;
      3'h1:    src[3] = s_cell1;
      3'h2:    src[3] = s_cmp3;
      3'h3:    src[3] = s_sdi;
      3'h6:    src[3] = s_oc1;
      3'h7:    src[3] = s_oc3;
      default: src[3] = 1'b0;                     // see RQ15
    endcase
  end

  // gate one/two from low word, three/four from high word
  assign gate_en = {en_hi_reg, en_lo_reg};        // see RQ9 see RQ11

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_gate
      assign gate_raw[g] = gate_or(gate_en[8*g+7:8*g], src);
      // inversion reaches both the gate_out port and what the cell sees
      assign gate_out[g] = gate_raw[g] ^ ctrl_hi_reg[g];  // see RQ1
    end
  endgenerate

  // cell function; clocked modes use rising gate one as their clock
  assign g1_rise = gate_out[0] & ~g1_prev_reg;

  always_comb begin
    cell_next = cell_out_reg;
    case (mode)                                   // see RQ12
      LCIR_AND_OR: begin
        cell_next = (gate_out[0] & gate_out[1]) | (gate_out[2] & gate_out[3]);
      end
      LCIR_OR_XOR: begin
        cell_next = (gate_out[0] | gate_out[1]) ^ (gate_out[2] | gate_out[3]);
      end
      LCIR_AND4: begin
        cell_next = &gate_out;
      end
      LCIR_SR_LATCH: begin
        // set wins when both are asserted
        if (gate_out[0] | gate_out[1]) begin
          cell_next = 1'b1;
        end else if (gate_out[2] | gate_out[3]) begin
          cell_next = 1'b0;
        end
      end
      LCIR_DFF_SR: begin
        if (gate_out[3]) begin
          cell_next = 1'b1;
        end else if (gate_out[2]) begin
          cell_next = 1'b0;
        end else if (g1_rise) begin
          cell_next = gate_out[1];
        end
      end
      LCIR_DFF2_R: begin
        if (gate_out[2]) begin
          cell_next = 1'b0;
        end else if (g1_rise) begin
          cell_next = gate_out[1] ^ gate_out[3];
        end
      end
      LCIR_JK_R: begin
        if (gate_out[2]) begin
          cell_next = 1'b0;
        end else if (g1_rise) begin
          case ({gate_out[1], gate_out[3]})
            2'b10:   cell_next = 1'b1;
            2'b01:   cell_next = 1'b0;
            2'b11:   cell_next = ~cell_out_reg;
            default: cell_next = cell_out_reg;
          endcase
        end
      end
      LCIR_LATCH_SR: begin
        if (gate_out[3]) begin
          cell_next = 1'b1;
        end else if (gate_out[2]) begin
          cell_next = 1'b0;
        end else if (gate_out[0]) begin
          cell_next = gate_out[1];                // transparent while open
        end
      end
      default: cell_next = 1'b0;
    endcase
    if (!ctrl_lo_reg[CTRL_EN_BIT]) begin
      cell_next = 1'b0;                           // see RQ13
    end
  end

  // cell state, sampled every pclk; edges slower than pclk only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_out_reg <= 1'b0;
      g1_prev_reg  <= 1'b0;
    end else begin
      cell_out_reg <= cell_next;
      g1_prev_reg  <= gate_out[0];
    end
  end

  assign cell_out = cell_out_reg;

  // register writes at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_lo_reg <= REG_RESET;
      ctrl_hi_reg <= REG_RESET;
      sel_reg     <= REG_RESET;
      en_lo_reg   <= REG_RESET;
      en_hi_reg   <= REG_RESET;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CTRL_LO: ctrl_lo_reg <= merge(ctrl_lo_reg, pwdata, pstrb, CTRL_LO_MASK);
        ADDR_CTRL_HI: ctrl_hi_reg <= merge(ctrl_hi_reg, pwdata, pstrb, CTRL_HI_MASK);
        ADDR_SEL:     sel_reg     <= merge(sel_reg, pwdata, pstrb, SEL_MASK); // see RQ6
        ADDR_EN_LO:   en_lo_reg   <= merge(en_lo_reg, pwdata, pstrb, 16'hFFFF);
        ADDR_EN_HI:   en_hi_reg   <= merge(en_hi_reg, pwdata, pstrb, 16'hFFFF);
        default:      ;                           // unmapped, ignored
      endcase
    end
  end

  // read mux; status bit shows the live cell output
  always_comb begin
    case (paddr)
      ADDR_CTRL_LO: rd_word = ctrl_lo_reg | (16'(cell_out_reg) << CTRL_OUT_BIT);
      ADDR_CTRL_HI: rd_word = ctrl_hi_reg;
      ADDR_SEL:     rd_word = sel_reg;
      ADDR_EN_LO:   rd_word = en_lo_reg;
      ADDR_EN_HI:   rd_word = en_hi_reg;
      default:      rd_word = REG_RESET;
    endcase
  end

  // read data and error captured in setup, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= {16'h0000, rd_word};
      pslverr <= ~hit;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_invert_idle:   assert property ((gate_en[7:0] == 8'h00)
                     |-> (gate_out[0] == ctrl_hi_reg[0])) // see RQ1
    else $error("idle gate one not equal to its invert bit");
  a_sel_one_pin:   assert property ((sel_reg[2:0] == 3'h0) |-> (src[0] == s_pin_a)) // see RQ2
    else $error("selector one code 0 not pin a");
  a_sel_two_cell:  assert property ((sel_reg[6:4] == 3'h1) |-> (src[1] == s_cell1)) // see RQ3
    else $error("selector two code 1 not cell one");
  a_sel_three_fb:  assert property ((sel_reg[10:8] == 3'h1)
                     |-> (src[2] == cell_out_reg)) // see RQ4
    else $error("selector three code 1 not own output");
  a_sel_four_gap:  assert property ((sel_reg[14:13] == 2'b10) |-> !src[3]) // see RQ5 see RQ15
    else $error("selector four gap code not zero");
  a_sel_one_gap:   assert property ((sel_reg[2:0] == 3'h5) |-> !src[0]) // see RQ15
    else $error("selector one gap code not zero");
  a_sel_write:     assert property (wr_en && paddr == ADDR_SEL && pstrb[1:0] == 2'b11
                     |=> sel_reg == ($past(pwdata[15:0]) & 16'h7777)) // see RQ6
    else $error("select write not stored with gaps cleared");
  a_true_term:     assert property ((en_lo_reg == 16'h0002 && !ctrl_hi_reg[0])
                     |-> gate_out[0] == src[0]) // see RQ7
    else $error("true enable not passing source");
  a_neg_term:      assert property ((en_lo_reg == 16'h0001 && !ctrl_hi_reg[0])
                     |-> gate_out[0] == !src[0]) // see RQ8
    else $error("negated enable not inverting source");
  a_gate_two_bits: assert property ((en_lo_reg == 16'h0200 && !ctrl_hi_reg[1])
                     |-> gate_out[1] == src[0] && !gate_raw[0]) // see RQ9 see RQ14
    else $error("gate two enable field misplaced");
  a_gate_three:    assert property ((en_hi_reg[7:0] == 8'h80 && !ctrl_hi_reg[2])
                     |-> gate_out[2] == src[3]) // see RQ11
    else $error("gate three enable field misplaced");
  a_cell_off:      assert property (!ctrl_lo_reg[CTRL_EN_BIT] |=> !cell_out) // see RQ13
    else $error("disabled cell output not zero");
  a_and4_mode:     assert property ((ctrl_lo_reg[CTRL_EN_BIT] && mode == LCIR_AND4)
                     |=> cell_out == $past(&gate_out)) // see RQ12
    else $error("four input and mode wrong");

  c_cell_high:   cover property (ctrl_lo_reg[CTRL_EN_BIT] ##1 cell_out);
  c_inverted:    cover property (ctrl_hi_reg[0] && gate_en[7:0] != 8'h00);
  c_jk_toggle:   cover property (mode == LCIR_JK_R && g1_rise ##1 $changed(cell_out));
  c_bad_address: cover property (psel && penable && pslverr);

endmodule
`default_nettype wire

// file: hdl/lcir_pkg.sv
// Purpose: shared constants for the logic cell input routing block
// Assumes: apb byte addresses are four times the register index
// Notes:   all configuration registers reset to zero
`default_nettype none
package lcir_pkg;
  // register indices as printed, byte address is index times four
  localparam logic [15:0] IDX_CTRL_LO = 16'h0470;
  localparam logic [15:0] IDX_CTRL_HI = 16'h0472;
  localparam logic [15:0] IDX_SEL     = 16'h0474;
  localparam logic [15:0] IDX_EN_LO   = 16'h0478;
  localparam logic [15:0] IDX_EN_HI   = 16'h047A;
  localparam logic [15:0] ADDR_CTRL_LO = {IDX_CTRL_LO[13:0], 2'b00};
  localparam logic [15:0] ADDR_CTRL_HI = {IDX_CTRL_HI[13:0], 2'b00};
  localparam logic [15:0] ADDR_SEL     = {IDX_SEL[13:0], 2'b00};
  localparam logic [15:0] ADDR_EN_LO   = {IDX_EN_LO[13:0], 2'b00};
  localparam logic [15:0] ADDR_EN_HI   = {IDX_EN_HI[13:0], 2'b00};
  // field positions
  localparam int CTRL_EN_BIT  = 15;   // cell_enable
  localparam int CTRL_OUT_BIT = 6;    // cell output status, read only
  localparam logic [15:0] CTRL_LO_MASK = 16'h8007; // writable bits
  localparam logic [15:0] CTRL_HI_MASK = 16'h000F; // gate invert bits
  localparam logic [15:0] SEL_MASK     = 16'h7777; // bits 15,11,7,3 absent
  localparam logic [15:0] REG_RESET    = 16'h0000;
  // cell modes
  typedef enum logic [2:0] {
    LCIR_AND_OR   = 3'b000,
    LCIR_OR_XOR   = 3'b001,
    LCIR_AND4     = 3'b010,
    LCIR_SR_LATCH = 3'b011,
    LCIR_DFF_SR   = 3'b100,
    LCIR_DFF2_R   = 3'b101,
    LCIR_JK_R     = 3'b110,
    LCIR_LATCH_SR = 3'b111
  } lcir_mode_e;
endpackage
`default_nettype wire

// file: dv/lcir_src_model.sv
// Purpose: far-side model of the pins and peripheral lines feeding the router
// Assumes: bench hands over the wanted source levels as one vector
// Notes:   levels change only just after a rising edge, like real logic
`default_nettype none
module lcir_src_model (
  input  wire logic        pclk,      // peripheral clock
  input  wire logic        presetn,   // async reset, active low
  input  wire logic [23:0] level_in,  // wanted level of each source
  output logic      [23:0] src_out    // source lines towards the router
);
  timeunit 1ns;
  timeprecision 1ps;
  // sources launch from a flop so the router never sees a same-edge change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_out <= 24'h00_0000;
    end else begin
      src_out <= level_in;
    end
  end
endmodule
`default_nettype wire

// file: dv/lcir_top_tb.sv
// Purpose: self-checking bench for the logic cell input routing block
// Assumes: zero wait apb slave, two-flop source synchronisers
// Notes:   source bits: 0 pin a, 7 pin b, 15 pin c, 21 pin d, others per route_idx
`default_nettype none
module lcir_top_tb
  import lcir_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite;   // apb request side
  logic [15:0] paddr;                                  // byte address
  logic [31:0] pwdata, prdata, rd;                     // bus data, last read
  logic [3:0]  pstrb;                                  // byte lanes
  logic        pready, pslverr, err;                   // answer, last error
  logic [23:0] lvl, src;                               // wanted and driven sources
  logic [3:0]  gate_out;                               // gate outputs
  logic        cell_out;                               // cell output
  int          n_fail, compares, k;                    // counters, source index
  logic [15:0] lo, hi;                                 // enable words of a case
  logic [3:0]  inv, pin, ex;                           // invert, pins, expected
  // source index per selector and code; -1 means constant zero expected
  int route_idx [4][8] = '{'{0, 1, 2, 3, 4, -1, 5, 6},
                           '{7, 8, 9, 10, 11, 12, 13, 14},
                           '{15, -1, 16, 17, 18, 19, 14, 20},
                           '{21, 8, 22, 23, -1, -1, 13, 20}};
  // en_lo, en_hi, invert, pins d..a, expected gate_out
  logic [43:0] gate_tab [13] = '{{16'h0001, 16'h0000, 4'h0, 4'h0, 4'h1},
    {16'h0001, 16'h0000, 4'h0, 4'h1, 4'h0}, {16'h0000, 16'h0000, 4'h0, 4'hF, 4'h0},
    {16'h8000, 16'h0000, 4'h0, 4'h8, 4'h2}, {16'h4000, 16'h0000, 4'h0, 4'hF, 4'h0},
    {16'h00A0, 16'h0000, 4'h0, 4'h4, 4'h1}, {16'h00A0, 16'h0000, 4'h0, 4'h0, 4'h0},
    {16'h0000, 16'h0000, 4'hF, 4'h0, 4'hF}, {16'h0000, 16'h0000, 4'h5, 4'h0, 4'h5},
    {16'h0000, 16'h0200, 4'h0, 4'h1, 4'h8}, {16'h0000, 16'h0008, 4'h0, 4'h2, 4'h4},
    {16'h0003, 16'h0000, 4'h0, 4'h0, 4'h1}, {16'h8000, 16'h0000, 4'h2, 4'h8, 4'h0}};

  lcir_src_model lcir_src_model_inst (.pclk(pclk), .presetn(presetn), .level_in(lvl),
    .src_out(src));

  lcir_top lcir_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gate_out(gate_out), .cell_out(cell_out),
    .cell_input_pin_a(src[0]), .peripheral_bus_clock(src[1]),
    .secondary_oscillator(src[2]), .low_power_rc_clock(src[3]),
    .reference_clock_out(src[4]), .timer_two_match(src[5]), .timer_three_match(src[6]),
    .cell_input_pin_b(src[7]), .logic_cell_one(src[8]), .comparator_one(src[9]),
    .serial_two_transmit(src[10]), .adc_done(src[11]), .dma_zero_irq(src[12]),
    .compare_output_one(src[13]), .compare_output_two(src[14]),
    .cell_input_pin_c(src[15]), .comparator_two(src[16]), .spi_two_data_out(src[17]),
    .serial_two_receive(src[18]), .dma_one_irq(src[19]),
    .compare_output_three(src[20]), .cell_input_pin_d(src[21]),
    .comparator_three(src[22]), .spi_two_data_in(src[23]));

  // 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // compare one value, count and report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rdchk(input string nm, input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask

  // new source levels, then wait out model flop plus two sync flops
  task automatic settle(input logic [23:0] v);
    @(posedge pclk);
    lvl <= v;
    repeat (3) @(posedge pclk);
    #1;
  endtask

  function automatic logic [23:0] pins(input logic [3:0] p);
    pins = {2'b00, p[3], 5'b0_0000, p[2], 7'h00, p[1], 6'h00, p[0]};
  endfunction

  task automatic finish_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog: the full run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    finish_test();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    lvl = 24'h00_0000;
    n_fail = 0;
    compares = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and access kinds
    rdchk("sel reset", ADDR_SEL, 32'h0000_0000);
    rdchk("en_lo reset", ADDR_EN_LO, 32'h0000_0000);
    rdchk("en_hi reset", ADDR_EN_HI, 32'h0000_0000);
    rdchk("ctrl_hi reset", ADDR_CTRL_HI, 32'h0000_0000);
    apb(1'b1, ADDR_SEL, 32'hFFFF_FFFF);
    rdchk("sel fields", ADDR_SEL, 32'h0000_7777);
    apb(1'b1, ADDR_EN_LO, 32'h0000_A55A);
    rdchk("en_lo rw", ADDR_EN_LO, 32'h0000_A55A);
    apb(1'b1, ADDR_EN_HI, 32'h0000_C33C);
    rdchk("en_hi rw", ADDR_EN_HI, 32'h0000_C33C);
    apb(1'b0, 16'h1FF0, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    // every code of every selector through the gate one true enable
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, ADDR_EN_LO, 32'h1 << (2 * s + 1));
      for (int c = 0; c < 8; c++) begin
        apb(1'b1, ADDR_SEL, 32'(c) << (4 * s));
        k = route_idx[s][c];
        if (k >= 0) begin
          settle(24'h00_0001 << k);
          chk($sformatf("sel%0d code%0d high", s + 1, c),
              32'h1, {31'h0, gate_out[0]});
          settle(~(24'h00_0001 << k));
          chk($sformatf("sel%0d code%0d low", s + 1, c),
              32'h0, {31'h0, gate_out[0]});
        end else begin
          // unimplemented code or this cell's idle fed-back output: zero whatever the sources do
          settle(24'hFF_FFFF);
          chk($sformatf("sel%0d code%0d zero", s + 1, c),
              32'h0, {31'h0, gate_out[0]});
        end
      end
    end
    // enable matrix, or-combine and gate invert on pins a..d
    apb(1'b1, ADDR_SEL, 32'h0000_0000);
    foreach (gate_tab[i]) begin
      {lo, hi, inv, pin, ex} = gate_tab[i];
      apb(1'b1, ADDR_EN_LO, {16'h0000, lo});
      apb(1'b1, ADDR_EN_HI, {16'h0000, hi});
      apb(1'b1, ADDR_CTRL_HI, {28'h000_0000, inv});
      settle(pins(pin));
      chk($sformatf("gate_out case %0d", i),
          {28'h0, ex}, {28'h0, gate_out});
    end
    // four-input and mode over all-high gates, then one gate low, then disabled
    apb(1'b1, ADDR_EN_LO, 32'h0000_0000);
    apb(1'b1, ADDR_EN_HI, 32'h0000_0000);
    apb(1'b1, ADDR_CTRL_HI, 32'h0000_000F);
    apb(1'b1, ADDR_CTRL_LO, 32'h0000_8002);
    settle(24'h00_0000);
    chk("and4 all high", 32'h1, {31'h0, cell_out});
    rdchk("ctrl_lo status", ADDR_CTRL_LO, 32'h0000_8042);
    apb(1'b1, ADDR_CTRL_HI, 32'h0000_0007);
    settle(24'h00_0000);
    chk("and4 one low", 32'h0, {31'h0, cell_out});
    apb(1'b1, ADDR_CTRL_HI, 32'h0000_000F);
    apb(1'b1, ADDR_CTRL_LO, 32'h0000_0002);
    settle(24'h00_0000);
    chk("cell disabled", 32'h0, {31'h0, cell_out});
    finish_test();
  end
endmodule
`default_nettype wire
